// >>> hdl/cis_regs.svh
// Register offsets, field positions, reset values and cycle counts of the interrupt sequencer.
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH

`define CIS_ADDR_W 3
`define CIS_OFS_FLAG 3'h0
`define CIS_OFS_ENABLE 3'h1
`define CIS_OFS_STATUS 3'h2
`define CIS_OFS_MCUCTRL 3'h3
`define CIS_OFS_SP_LO 3'h4
`define CIS_OFS_SP_HI 3'h5
`define CIS_OFS_PENDING 3'h6

`define CIS_STATUS_GIE_BIT 7
`define CIS_MCUCTRL_VECTOR_SELECT_BIT_BIT 1

`define CIS_FLAG_RST 8'h00
`define CIS_ENABLE_RST 8'h00
`define CIS_SP_RST 16'h0AFF

`define CIS_ENTRY_CYC 5
`define CIS_VEC_JUMP_CYC 3
`define CIS_WAKE_CYC 5
`define CIS_RET_CYC 5
`define CIS_PC_BYTES 3

`endif

// >>> hdl/cis_pkg.sv
// Types shared by the interrupt sequencer and its surroundings.
package cis_pkg;

  typedef enum logic [1:0] {
    CIS_IDLE,
    CIS_ENTRY,
    CIS_VEC,
    CIS_RET
  } cis_state_e;

  // Instruction-boundary report from the core pipeline.
  typedef struct packed {
    logic instr_done;
    logic set_gie;
    logic clr_gie;
    logic ret_int;
    logic sleeping;
  } cis_core_s;

  // Stack memory access request, one byte per cycle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cis_stack_s;

  // Program counter redirect toward the core.
  typedef struct packed {
    logic load;
    logic [15:0] pc;
  } cis_pc_s;

endpackage

// >>> hdl/cis_sequencer.sv
// Reset and interrupt sequencer: masking, priority, vector entry and return.
`timescale 1ns/1ps
`include "cis_regs.svh"

module cis_sequencer
  import cis_pkg::*;
#(
  parameter int NUM_SRC = 8,
  parameter logic [7:0] FLAG_SRC = 8'hFF,
  parameter logic [15:0] BOOT_START = 16'h3800,
  parameter logic [15:0] VEC_SIZE = 16'h0002
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [`CIS_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Interrupt sources.
  input wire logic [NUM_SRC-1:0] src_event_i,
  input wire logic [NUM_SRC-1:0] src_level_i,
  // Static configuration pins.
  input wire logic boot_reset_fuse_i,
  input wire logic boot_lock_bit_02_i,
  input wire logic boot_lock_bit_12_i,
  // Core pipeline.
  input wire cis_core_s core_i,
  input wire logic [15:0] core_pc_i,
  output logic core_hold_o,
  output cis_pc_s pc_o,
  output logic [15:0] reset_vec_o,
  // Stack memory.
  output cis_stack_s stack_o,
  input wire logic [7:0] stack_rdata_i
);

  cis_state_e state_r;
  logic [3:0] step_r;
  logic [3:0] len_r;
  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] enable_r;
  logic gie_r;
  logic vector_select_bit_r;
  logic [15:0] sp_r;
  logic [15:0] ret_pc_r;
  logic [15:0] pop_pc_r;
  logic [$clog2(NUM_SRC)-1:0] sel_r;
  logic [2:0] fuse_r0;
  logic [2:0] fuse_r1;
  logic [2:0] fuse_r2;
  logic [2:0] fuse_r;

  logic [NUM_SRC-1:0] req_w;
  logic [$clog2(NUM_SRC)-1:0] win_w;
  logic any_w;
  logic locked_w;
  logic boundary_w;
  logic accept_w;
  logic entry_done_w;
  logic ret_start_w;
  logic ret_done_w;
  logic [15:0] vec_base_w;
  logic [15:0] vec_addr_w;
  localparam int SEL_W = $clog2(NUM_SRC);

  // Configuration pins come from outside the clock domain; a change counts once two stages agree.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fuse_r0 <= 3'h0;
      fuse_r1 <= 3'h0;
      fuse_r2 <= 3'h0;
      fuse_r <= 3'h0;
    end
    else
    begin
      fuse_r0 <= {boot_lock_bit_12_i, boot_lock_bit_02_i, boot_reset_fuse_i};
      fuse_r1 <= fuse_r0;
      fuse_r2 <= fuse_r1;
      if (fuse_r1 == fuse_r2)
        fuse_r <= fuse_r2;
    end
  end

  // Flag-type sources latch events, level-type sources pass their condition.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      always_ff @(posedge sys_clk_i or posedge reset_i)
      begin
        if (reset_i)
          flag_r[g] <= 1'(`CIS_FLAG_RST >> g);
        else if (FLAG_SRC[g] && src_event_i[g])
          flag_r[g] <= 1'b1; // set wins over any clear
        else if (accept_w && win_w == SEL_W'(g))
          flag_r[g] <= 1'b0;
        else if (reg_wr_i && reg_addr_i == `CIS_OFS_FLAG && reg_wdata_i[g])
          flag_r[g] <= 1'b0;
      end
      assign req_w[g] = (FLAG_SRC[g] ? flag_r[g] : src_level_i[g]) & enable_r[g];
    end
  endgenerate

  // Lowest index is the lowest vector address and so the highest priority.
  always_comb
  begin
    win_w = '0;
    any_w = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_w[i])
      begin
        win_w = i[$clog2(NUM_SRC)-1:0];
        any_w = 1'b1;
      end
    end
  end

  // Vectors follow the reset slot; the table moves with vector_select_bit.
  assign vec_base_w = vector_select_bit_r ? BOOT_START : 16'h0000;
  assign vec_addr_w = 16'(vec_base_w + (16'(sel_r) + 16'h0001) * VEC_SIZE);

  // Lock bits shut interrupts off when code and vectors sit in different sections.
  always_comb
  begin
    locked_w = 1'b0;
    if (fuse_r[1] && vector_select_bit_r && core_pc_i < BOOT_START)
      locked_w = 1'b1;
    if (fuse_r[2] && !vector_select_bit_r && core_pc_i >= BOOT_START)
      locked_w = 1'b1;
  end

  // Requests are taken only between instructions or while the core sleeps, never on the set-enable or return boundary.
  assign boundary_w = (core_i.instr_done && !core_i.set_gie && !core_i.ret_int)
    || core_i.sleeping;
  // The clear-enable instruction masks in its own cycle.
  assign accept_w = state_r == CIS_IDLE && boundary_w && gie_r && !core_i.clr_gie
    && any_w && !locked_w;
  assign ret_start_w = state_r == CIS_IDLE && core_i.instr_done && core_i.ret_int;
  assign entry_done_w = state_r == CIS_ENTRY && step_r == len_r;
  assign ret_done_w = state_r == CIS_RET && step_r == 4'(`CIS_RET_CYC - 1);

  // Sequencing of entry, vector jump and return.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= CIS_IDLE;
      step_r <= 4'h0;
      len_r <= 4'h0;
      sel_r <= '0;
      ret_pc_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        CIS_IDLE:
        begin
          step_r <= 4'h0;
          if (accept_w)
          begin
            state_r <= CIS_ENTRY;
            sel_r <= win_w;
            ret_pc_r <= core_pc_i;
            len_r <= core_i.sleeping ? 4'(`CIS_ENTRY_CYC + `CIS_WAKE_CYC - 1)
                                     : 4'(`CIS_ENTRY_CYC - 1);
          end
          else if (ret_start_w)
            state_r <= CIS_RET;
        end
        CIS_ENTRY:
        begin
          step_r <= 4'(step_r + 4'h1);
          if (entry_done_w)
          begin
            state_r <= CIS_VEC;
            step_r <= 4'h0;
          end
        end
        CIS_VEC:
        begin
          step_r <= 4'(step_r + 4'h1);
          if (step_r == 4'(`CIS_VEC_JUMP_CYC - 1))
            state_r <= CIS_IDLE;
        end
        CIS_RET:
        begin
          step_r <= 4'(step_r + 4'h1);
          if (ret_done_w)
            state_r <= CIS_IDLE;
        end
        default:
          state_r <= CIS_IDLE;
      endcase
    end
  end

  // Global enable: entry clears it, return and software set it.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      gie_r <= 1'b0;
    else if (accept_w)
      gie_r <= 1'b0;
    else if (ret_done_w)
      gie_r <= 1'b1;
    else if (core_i.instr_done && core_i.clr_gie)
      gie_r <= 1'b0;
    else if (core_i.instr_done && core_i.set_gie)
      gie_r <= 1'b1;
    else if (reg_wr_i && reg_addr_i == `CIS_OFS_STATUS)
      gie_r <= reg_wdata_i[`CIS_STATUS_GIE_BIT];
  end

  // Stack pointer moves by three on entry and on return.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      sp_r <= `CIS_SP_RST;
    else if (entry_done_w)
      sp_r <= 16'(sp_r - 16'(`CIS_PC_BYTES));
    else if (ret_done_w)
      sp_r <= 16'(sp_r + 16'(`CIS_PC_BYTES));
    else if (reg_wr_i && reg_addr_i == `CIS_OFS_SP_LO)
      sp_r[7:0] <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == `CIS_OFS_SP_HI)
      sp_r[15:8] <= reg_wdata_i;
  end

  // Stack traffic: three pushes on entry, three pops on return, third byte popped first, then high, then low.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stack_o <= '0;
      pop_pc_r <= 16'h0000;
    end
    else
    begin
      stack_o.wr <= 1'b0;
      stack_o.rd <= 1'b0;
      if (state_r == CIS_ENTRY && step_r < 4'(`CIS_PC_BYTES))
      begin
        stack_o.wr <= 1'b1;
        stack_o.addr <= 16'(sp_r - 16'(step_r));
        stack_o.wdata <= step_r == 4'h0 ? ret_pc_r[7:0] :
                         step_r == 4'h1 ? ret_pc_r[15:8] : 8'h00;
      end
      if (state_r == CIS_RET && step_r < 4'(`CIS_PC_BYTES))
      begin
        stack_o.rd <= 1'b1;
        stack_o.addr <= 16'(sp_r + 16'(step_r) + 16'h0001);
      end
      // Read data stand one cycle after each pop request.
      if (state_r == CIS_RET && step_r == 4'h3)
        pop_pc_r[15:8] <= stack_rdata_i;
      if (state_r == CIS_RET && step_r == 4'h4)
        pop_pc_r[7:0] <= stack_rdata_i;
    end
  end

  // Core redirect and stall.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pc_o <= '0;
      core_hold_o <= 1'b0;
      reset_vec_o <= 16'h0000;
    end
    else
    begin
      reset_vec_o <= fuse_r[0] ? BOOT_START : 16'h0000;
      pc_o.load <= 1'b0;
      core_hold_o <= accept_w || ret_start_w
        || (state_r == CIS_ENTRY && !entry_done_w)
        || (state_r == CIS_RET && !ret_done_w);
      if (entry_done_w)
      begin
        pc_o.load <= 1'b1;
        pc_o.pc <= vec_addr_w;
      end
      // The popped byte arrives with the last return cycle.
      if (ret_done_w)
      begin
        pc_o.load <= 1'b1;
        pc_o.pc <= {pop_pc_r[15:8], stack_rdata_i};
      end
    end
  end

  // Software-owned controls.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      enable_r <= NUM_SRC'(`CIS_ENABLE_RST);
      vector_select_bit_r <= 1'b0;
    end
    else if (reg_wr_i && reg_addr_i == `CIS_OFS_ENABLE)
      enable_r <= reg_wdata_i[NUM_SRC-1:0];
    else if (reg_wr_i && reg_addr_i == `CIS_OFS_MCUCTRL)
      vector_select_bit_r <= reg_wdata_i[`CIS_MCUCTRL_VECTOR_SELECT_BIT_BIT];
  end

  // Read data, valid in the cycle after the strobe only.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (!reg_rd_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      case (reg_addr_i)
        `CIS_OFS_FLAG: reg_rdata_o <= 8'(flag_r);
        `CIS_OFS_ENABLE: reg_rdata_o <= 8'(enable_r);
        `CIS_OFS_STATUS: reg_rdata_o <= {gie_r, 5'h00, 2'(state_r)};
        `CIS_OFS_MCUCTRL: reg_rdata_o <= {6'h00, vector_select_bit_r, 1'b0};
        `CIS_OFS_SP_LO: reg_rdata_o <= sp_r[7:0];
        `CIS_OFS_SP_HI: reg_rdata_o <= sp_r[15:8];
        `CIS_OFS_PENDING: reg_rdata_o <= 8'(req_w);
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  AST_GIE_CLEARED_ON_ENTRY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    accept_w |=> !gie_r)
    else $error("Global enable still set after entry.");

  AST_NO_TAKE_WITHOUT_ENABLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    accept_w |-> gie_r && enable_r[win_w])
    else $error("Interrupt taken while masked.");

  AST_CLI_MASKS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (core_i.instr_done && core_i.clr_gie && state_r == CIS_IDLE) |-> !accept_w ##1 !gie_r)
    else $error("Interrupt taken beside clear-enable.");

  AST_ENTRY_FIVE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (accept_w && !core_i.sleeping) |-> ##1 core_hold_o [*5] ##1 (pc_o.load && !core_hold_o))
    else $error("Entry did not take five cycles.");

  AST_WAKE_TEN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (accept_w && core_i.sleeping) |-> ##10 entry_done_w)
    else $error("Wake entry not five cycles longer.");

  AST_SP_DOWN_THREE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    entry_done_w |=> sp_r == 16'($past(sp_r) - 16'h0003))
    else $error("Stack pointer not lowered by three.");

  AST_RET_FIVE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ret_start_w |-> ##1 core_hold_o [*5] ##1 (pc_o.load && !core_hold_o && gie_r
      && sp_r == 16'($past(sp_r, 6) + 16'h0003)))
    else $error("Return not completed in five cycles.");

  AST_HIGHEST_WINS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    accept_w |-> (req_w & NUM_SRC'((1 << win_w) - 1)) == '0)
    else $error("Lower-priority source taken.");

  AST_FLAG_CLEARED: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (accept_w && FLAG_SRC[win_w] && !src_event_i[win_w]) |=> !flag_r[$past(win_w)])
    else $error("Flag not cleared on vectoring.");

  AST_VEC_JUMP_THREE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    entry_done_w |=> (state_r == CIS_VEC) [*3] ##1 (state_r == CIS_IDLE))
    else $error("Vector jump not three cycles.");

endmodule // cis_sequencer

// >>> tb/cis_stack_model.sv
// Stack memory model that answers the sequencer's pushes and pops.
`timescale 1ns/1ps
module cis_stack_model
  import cis_pkg::*;
(
  // Clock.
  input wire logic sys_clk_i,
  // Stack port.
  input wire cis_stack_s stack_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_r [0:4095];

  // A read answers in the next cycle only; otherwise the bus is released and toggles.
  always @(posedge sys_clk_i)
  begin
    if (stack_i.wr)
    begin
      mem_r[stack_i.addr[11:0]] <= stack_i.wdata;
    end
    if (stack_i.rd)
    begin
      rdata_o <= mem_r[stack_i.addr[11:0]];
    end
    else
    begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule // cis_stack_model

// >>> tb/tb_cpu_interrupt_sequencer.sv
// Self-checking testbench of the interrupt sequencer.
`timescale 1ns/1ps
`include "cis_regs.svh"
module tb_cpu_interrupt_sequencer;
  import cis_pkg::*;
  localparam logic [15:0] BOOT = 16'h3800;
  logic clk, rst, wr, rd, fuse;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, ev, srd, d, lvl;
  logic [1:0] lk;
  logic [15:0] pc_in, rvec, last_pc;
  logic hold;
  cis_core_s core;
  cis_pc_s pco;
  cis_stack_s stk;
  logic [23:0] wq [$];
  int fails = 0;
  int tests_run = 0;
  int hold_cnt = 0;
  int pc_cnt = 0;
  int n;

  cis_sequencer #(.NUM_SRC(8), .FLAG_SRC(8'h7F), .BOOT_START(BOOT), .VEC_SIZE(16'h0002)) uut (
    .sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .src_event_i(ev), .src_level_i(lvl),
    .boot_reset_fuse_i(fuse), .boot_lock_bit_02_i(lk[0]), .boot_lock_bit_12_i(lk[1]),
    .core_i(core), .core_pc_i(pc_in), .core_hold_o(hold), .pc_o(pco), .reset_vec_o(rvec),
    .stack_o(stk), .stack_rdata_i(srd));

  cis_stack_model partner (.sys_clk_i(clk), .stack_i(stk), .rdata_o(srd));

  always #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    if (hold === 1'b1) hold_cnt++;
    if (pco.load === 1'b1)
    begin
      pc_cnt++;
      last_pc = pco.pc;
    end
    if (stk.wr === 1'b1) wq.push_back({stk.addr, stk.wdata});
  end

  task automatic test_done();
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic instr(input logic s, input logic c, input logic r, input logic [15:0] pc);
    @(posedge clk);
    core <= {1'b1, s, c, r, 1'b0};
    pc_in <= pc;
    @(posedge clk);
    core <= '0;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask

  task automatic wait_load(input int n0);
    for (int i = 0; i < 40 && pc_cnt == n0; i++) @(posedge clk);
    if (pc_cnt == n0)
    begin
      fails++;
      $display("MISMATCH %0t no vector load", $time);
      test_done();
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic quiet(input int cyc, input string m);
    int h0;
    h0 = hold_cnt;
    repeat (cyc) @(posedge clk);
    #1 chk(hold_cnt, h0, m);
  endtask

  task automatic t_reset();
    rd_reg(3'h0); chk(d, `CIS_FLAG_RST, "flag reset value");
    rd_reg(3'h1); chk(d, `CIS_ENABLE_RST, "enable reset value");
    rd_reg(3'h2); chk(d, 8'h00, "status reset value");
    rd_reg(3'h4); chk(d, 8'hFF, "stack low reset value");
    rd_reg(3'h5); chk(d, 8'h0A, "stack high reset value");
    wr_reg(3'h7, 8'hFF);
    rd_reg(3'h7); chk(d, 8'h00, "unmapped index");
    chk(rvec, 16'h0000, "reset vector at zero");
  endtask

  task automatic t_flags();
    pulse(8'h04);
    rd_reg(3'h0); chk(d, 8'h04, "flag held while disabled");
    wr_reg(3'h0, 8'h00);
    rd_reg(3'h0); chk(d, 8'h04, "zero write kept flag");
    wr_reg(3'h0, 8'h04);
    rd_reg(3'h0); chk(d, 8'h00, "one write cleared flag");
  endtask

  task automatic t_entry();
    wr_reg(3'h1, 8'h0A);
    pulse(8'h0A);
    instr(1'b0, 1'b0, 1'b0, 16'h1000);
    quiet(8, "entry with global enable clear");
    wr_reg(3'h2, 8'h80);
    quiet(6, "entry without boundary");
    wq.delete();
    hold_cnt = 0;
    n = pc_cnt;
    instr(1'b0, 1'b0, 1'b0, 16'h1234);
    wait_load(n);
    chk(last_pc, 16'h0004, "vector of lowest source");
    chk(hold_cnt, `CIS_ENTRY_CYC, "entry length");
    chk(wq.size(), 3, "push count");
    if (wq.size() == 3)
    begin
      chk(wq[0], {16'h0AFF, 8'h34}, "push low byte");
      chk(wq[1], {16'h0AFE, 8'h12}, "push high byte");
      chk(wq[2], {16'h0AFD, 8'h00}, "push third byte");
    end
    rd_reg(3'h0); chk(d, 8'h08, "taken flag cleared, other kept");
    rd_reg(3'h2); chk(d[7], 1'b0, "global enable cleared");
    rd_reg(3'h4); chk(d, 8'hFC, "stack lowered by three");
  endtask

  task automatic t_return();
    n = pc_cnt;
    instr(1'b0, 1'b0, 1'b1, 16'h0000);
    wait_load(n);
    chk(last_pc, 16'h1234, "popped return address");
    quiet(6, "entry right after return");
    rd_reg(3'h2); chk(d[7], 1'b1, "global enable set by return");
    rd_reg(3'h4); chk(d, 8'hFF, "stack raised by three");
    n = pc_cnt;
    instr(1'b0, 1'b0, 1'b0, 16'h2000);
    wait_load(n);
    chk(last_pc, 16'h0008, "held flag served later");
    rd_reg(3'h0); chk(d, 8'h00, "all flags served");
  endtask

  task automatic t_mask();
    wr_reg(3'h1, 8'h01);
    wr_reg(3'h2, 8'h80);
    pulse(8'h01);
    n = pc_cnt;
    instr(1'b1, 1'b0, 1'b0, 16'h3000);
    quiet(6, "entry after set instruction");
    instr(1'b0, 1'b1, 1'b0, 16'h3001);
    quiet(6, "entry after clear instruction");
    rd_reg(3'h2); chk(d[7], 1'b0, "clear instruction masks");
    instr(1'b1, 1'b0, 1'b0, 16'h3002);
    instr(1'b0, 1'b0, 1'b0, 16'h3003);
    wait_load(n);
    chk(last_pc, 16'h0002, "source zero vector");
  endtask

  task automatic t_boot();
    wr_reg(3'h3, 8'h02);
    wr_reg(3'h1, 8'h20);
    instr(1'b1, 1'b0, 1'b0, 16'h4000);
    @(posedge clk);
    core <= {4'h0, 1'b1};
    hold_cnt = 0;
    n = pc_cnt;
    pulse(8'h20);
    wait_load(n);
    core <= '0;
    chk(last_pc, BOOT + 16'h000C, "relocated vector");
    chk(hold_cnt, `CIS_ENTRY_CYC + `CIS_WAKE_CYC, "wake entry length");
    fuse <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(rvec, BOOT, "reset vector in boot section");
  endtask

  task automatic t_level();
    @(posedge clk);
    wr_reg(3'h1, 8'h80);
    lvl <= 8'h80;
    repeat (3) @(posedge clk);
    lvl <= 8'h00;
    wr_reg(3'h2, 8'h80);
    instr(1'b0, 1'b0, 1'b0, 16'h1000);
    quiet(6, "vanished level condition taken");
    @(posedge clk);
    lk <= 2'b01;
    lvl <= 8'h80;
    rd_reg(3'h6); chk(d, 8'h80, "level request pending");
    repeat (6) @(posedge clk);
    instr(1'b0, 1'b0, 1'b0, 16'h1000);
    quiet(6, "entry while boot lock active");
    @(posedge clk);
    lk <= 2'b00;
    repeat (6) @(posedge clk);
    n = pc_cnt;
    instr(1'b0, 1'b0, 1'b0, 16'h1000);
    wait_load(n);
    lvl <= 8'h00;
    chk(last_pc, BOOT + 16'h0010, "level source vector");
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {wr, rd, fuse, addr, wdata, ev, pc_in, lvl, lk} = '0;
    core = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_entry();
    t_return();
    t_mask();
    t_boot();
    t_level();
    test_done();
  end
endmodule // tb_cpu_interrupt_sequencer
